// ---- shared/cgr_regs.svh ----
// register offsets, field positions, reset values and constants of the reference and divider block
`ifndef CGR_REGS_SVH
`define CGR_REGS_SVH

// ********
// register offsets
// ********
`define CGR_OFS_XTAL_DRIVE 8'h06
`define CGR_OFS_XTAL_LOAD 8'h07
`define CGR_OFS_REF_SELECT 8'h34
`define CGR_OFS_PLL0_SPREAD_CTRL 8'h60
`define CGR_OFS_PLL0_SPREAD_OFFSET 8'h61
`define CGR_OFS_PLL1_SPREAD_CTRL 8'h68
`define CGR_OFS_PLL1_SPREAD_OFFSET 8'h69
`define CGR_OFS_PRESCALE_BASE 8'h40
`define CGR_OFS_FEEDBACK_BASE 8'h48
`define CGR_OFS_POSTDIV_BASE 8'h50
`define CGR_OFS_BANK1_SOURCE 8'h5a

// ********
// field positions
// ********
`define CGR_PRIMARY_BIT 0
`define CGR_POLICY_LSB 1
`define CGR_POLICY_MSB 2
`define CGR_DRIVE_MSB 1
`define CGR_ADJUST_LSB 4
`define CGR_ADJUST_MSB 7
`define CGR_NHIGH_MSB 3
`define CGR_SPREAD_CTRL_MSB 3
`define CGR_SPREAD_OFS_MSB 5
`define CGR_QHIGH_MSB 1
`define CGR_PM_LSB 2
`define CGR_PM_MSB 3
`define CGR_SRC_LSB 4
`define CGR_SRC_MSB 5

// ********
// reset values
// ********
`define CGR_RST_XTAL_DRIVE 8'h03
`define CGR_RST_DEFAULT 8'h00

// ********
// codes and constants
// ********
`define CGR_PM_OFF 2'h0
`define CGR_PM_DIV1 2'h1
`define CGR_PM_DIV2 2'h2
`define CGR_PM_QDIV 2'h3
`define CGR_MFC_MODE2 2'h2
`define CGR_LOAD_BASE_EIGHTHS 9'h01c
`define CGR_FRAC_BITS 6
`define CGR_QDIV_OFFSET 11'h002

`endif

// ---- shared/cgr_pkg.sv ----
// types shared by the reference selection and divider block
package cgr_pkg;

    // per-PLL state as seen by the analog side
    typedef struct packed {
        logic powered;
        logic vco_min;
        logic [19:0] ratio_q6;
    } cgr_pll_status_t;

    // decoded post-divider setting of one bank
    typedef struct packed {
        logic [1:0] mode;
        logic [9:0] q;
        logic [1:0] source;
    } cgr_bank_cfg_t;

endpackage : cgr_pkg

// ---- verilog/cgr_prescale.sv ----
// integer pre-scaler dividing the selected reference by a programmable count
`timescale 1ns/10ps
module cgr_prescale #(
    parameter int D_WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ref_level_i,
    input wire logic [D_WIDTH-1:0] divide_i,
    output logic pfd_tick_o,
    output logic powered_o
);

    generate
        if (D_WIDTH < 1) begin : g_bad_width
            $error("cgr_prescale: D_WIDTH must be at least 1");
        end
    endgenerate

    logic ref_prev_reg;
    logic ref_prev_next;
    logic [D_WIDTH-1:0] count_reg;
    logic [D_WIDTH-1:0] count_next;
    logic tick_reg;
    logic tick_next;
    logic powered_reg;
    logic powered_next;

    always_comb begin
        ref_prev_next = ref_level_i;
        count_next = count_reg;
        tick_next = 1'b0;
        powered_next = (divide_i != '0);
        if (divide_i == '0) begin
            count_next = '0;
        end else if (ref_level_i && !ref_prev_reg) begin
            if (count_reg >= divide_i - 1'b1) begin
                count_next = '0;
                tick_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ref_prev_reg <= 1'b0;
            count_reg <= '0;
            tick_reg <= 1'b0;
            powered_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_prev_next;
            count_reg <= count_next;
            tick_reg <= tick_next;
            powered_reg <= powered_next;
        end
    end

    assign pfd_tick_o = tick_reg;
    assign powered_o = powered_reg;

endmodule : cgr_prescale

// ---- verilog/cgr_postdiv.sv ----
// post-divider of one output bank followed by the fixed divide-by-two stage
`timescale 1ns/10ps
`include "cgr_regs.svh"
module cgr_postdiv #(
    parameter int Q_WIDTH = 10
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic vco_tick_i,
    input wire logic powered_i,
    input wire logic [1:0] mode_i,
    input wire logic [Q_WIDTH-1:0] q_i,
    output logic bank_clk_o,
    output logic running_o
);

    generate
        if (Q_WIDTH < 1) begin : g_bad_width
            $error("cgr_postdiv: Q_WIDTH must be at least 1");
        end
    endgenerate

    logic [Q_WIDTH:0] ratio;
    logic [Q_WIDTH:0] count_reg;
    logic [Q_WIDTH:0] count_next;
    logic half_reg;
    logic half_next;
    logic run_reg;
    logic run_next;

    // total divide value of the programmable stage
    always_comb begin
        unique case (mode_i)
            `CGR_PM_OFF: ratio = (Q_WIDTH+1)'(1);
            `CGR_PM_DIV1: ratio = (Q_WIDTH+1)'(1);
            `CGR_PM_DIV2: ratio = (Q_WIDTH+1)'(2);
            `CGR_PM_QDIV: ratio = {1'b0, q_i} + (Q_WIDTH+1)'(`CGR_QDIV_OFFSET);
        endcase
    end

    always_comb begin
        count_next = count_reg;
        half_next = half_reg;
        run_next = powered_i && (mode_i != `CGR_PM_OFF);
        if (!powered_i || mode_i == `CGR_PM_OFF) begin
            // unpowered or switched-off bank stays quiet with its counter cleared
            count_next = '0;
            half_next = 1'b0;
        end else if (vco_tick_i) begin
            if (count_reg >= ratio - 1'b1) begin
                count_next = '0;
                half_next = !half_reg;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            count_reg <= '0;
            half_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            half_reg <= half_next;
            run_reg <= run_next;
        end
    end

    assign bank_clk_o = half_reg;
    assign running_o = run_reg;

endmodule : cgr_postdiv

// ---- verilog/cgr_ref_pll_cfg.sv ----
// reference selection, configuration registers and divider control of the three-PLL clock generator
`timescale 1ns/10ps
`include "cgr_regs.svh"
module cgr_ref_pll_cfg #(
    parameter int NUM_PLLS = 3,
    parameter int NUM_DIV_BANKS = 5
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [7:0] cfg_wdata_i,
    output logic [7:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic crystal_reference_input_i,
    input wire logic second_reference_input_i,
    input wire logic multipurpose_input_five_i,
    input wire logic [1:0] manual_frequency_control_i,
    input wire logic [NUM_PLLS-1:0] vco_tick_i,
    output logic selected_ref_o,
    output logic ref_is_secondary_o,
    output logic [NUM_PLLS-1:0] pfd_tick_o,
    output cgr_pkg::cgr_pll_status_t [NUM_PLLS-1:0] pll_status_o,
    output logic [8:0] crystal_load_eighths_o,
    output logic [1:0] crystal_drive_strength_o,
    output logic [1:0] switchover_policy_o,
    output logic [NUM_DIV_BANKS:0] bank_clk_o,
    output logic [NUM_DIV_BANKS:0] bank_powered_o
);

    // ********
    // elaboration checks
    // ********
    generate
        if (NUM_PLLS != 3) begin : g_bad_plls
            $error("cgr_ref_pll_cfg: register map serves exactly three PLLs");
        end
        if (NUM_DIV_BANKS != 5) begin : g_bad_banks
            $error("cgr_ref_pll_cfg: register map serves exactly five divided banks");
        end
    endgenerate

    // ********
    // register storage indices
    // ********
    localparam int IDX_DRIVE = 0;
    localparam int IDX_LOAD = 1;
    localparam int IDX_REFSEL = 2;
    localparam int IDX_SS0_CTRL = 3;
    localparam int IDX_SS0_OFS = 4;
    localparam int IDX_SS1_CTRL = 5;
    localparam int IDX_SS1_OFS = 6;
    localparam int IDX_PRE = 7;
    localparam int IDX_FB = IDX_PRE + NUM_PLLS;
    localparam int IDX_POST = IDX_FB + 2 * NUM_PLLS;
    localparam int IDX_BANK1 = IDX_POST + 2 * NUM_DIV_BANKS;
    localparam int REG_COUNT = IDX_BANK1 + 1;

    logic [7:0] cfg_reg [REG_COUNT];
    logic [7:0] cfg_next [REG_COUNT];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic hit;
    logic [4:0] hit_idx;

    // ********
    // address decode
    // ********
    function automatic logic [5:0] decode_addr(input logic [7:0] addr);
        logic [7:0] rel;
        rel = 8'h00;
        if (addr == `CGR_OFS_XTAL_DRIVE) begin
            return {1'b1, 5'(IDX_DRIVE)};
        end else if (addr == `CGR_OFS_XTAL_LOAD) begin
            return {1'b1, 5'(IDX_LOAD)};
        end else if (addr == `CGR_OFS_REF_SELECT) begin
            return {1'b1, 5'(IDX_REFSEL)};
        end else if (addr == `CGR_OFS_PLL0_SPREAD_CTRL) begin
            return {1'b1, 5'(IDX_SS0_CTRL)};
        end else if (addr == `CGR_OFS_PLL0_SPREAD_OFFSET) begin
            return {1'b1, 5'(IDX_SS0_OFS)};
        end else if (addr == `CGR_OFS_PLL1_SPREAD_CTRL) begin
            return {1'b1, 5'(IDX_SS1_CTRL)};
        end else if (addr == `CGR_OFS_PLL1_SPREAD_OFFSET) begin
            return {1'b1, 5'(IDX_SS1_OFS)};
        end else if (addr == `CGR_OFS_BANK1_SOURCE) begin
            return {1'b1, 5'(IDX_BANK1)};
        end else if (addr >= `CGR_OFS_PRESCALE_BASE && addr < `CGR_OFS_PRESCALE_BASE + 8'(NUM_PLLS)) begin
            rel = addr - `CGR_OFS_PRESCALE_BASE;
            return {1'b1, 5'(IDX_PRE) + rel[4:0]};
        end else if (addr >= `CGR_OFS_FEEDBACK_BASE && addr < `CGR_OFS_FEEDBACK_BASE + 8'(2 * NUM_PLLS)) begin
            rel = addr - `CGR_OFS_FEEDBACK_BASE;
            return {1'b1, 5'(IDX_FB) + rel[4:0]};
        end else if (addr >= `CGR_OFS_POSTDIV_BASE && addr < `CGR_OFS_POSTDIV_BASE + 8'(2 * NUM_DIV_BANKS)) begin
            rel = addr - `CGR_OFS_POSTDIV_BASE;
            return {1'b1, 5'(IDX_POST) + rel[4:0]};
        end
        return 6'h00;
    endfunction : decode_addr

    assign {hit, hit_idx} = decode_addr(cfg_addr_i);

    // ********
    // register file
    // ********
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        rdata_next = 8'h00;
        rvalid_next = cfg_rd_i;
        if (cfg_wr_i && hit) begin
            cfg_next[hit_idx] = cfg_wdata_i;
        end
        if (cfg_rd_i && hit) begin
            rdata_next = cfg_reg[hit_idx];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                cfg_reg[i] <= (i == IDX_DRIVE) ? `CGR_RST_XTAL_DRIVE : `CGR_RST_DEFAULT;
            end
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            for (int i = 0; i < REG_COUNT; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ********
    // reference selection
    // ********
    logic primary_source_bit;
    logic primary_ref;
    logic secondary_ref;
    logic use_secondary;
    logic sel_ref_reg;
    logic sel_ref_next;
    logic sec_reg;
    logic sec_next;

    assign primary_source_bit = cfg_reg[IDX_REFSEL][`CGR_PRIMARY_BIT];

    always_comb begin
        primary_ref = primary_source_bit ? second_reference_input_i : crystal_reference_input_i;
        secondary_ref = primary_source_bit ? crystal_reference_input_i : second_reference_input_i;
        use_secondary = multipurpose_input_five_i;
        if (manual_frequency_control_i == `CGR_MFC_MODE2) begin
            use_secondary = 1'b0;
        end
        sec_next = use_secondary;
        sel_ref_next = use_secondary ? secondary_ref : primary_ref;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sel_ref_reg <= 1'b0;
            sec_reg <= 1'b0;
        end else begin
            sel_ref_reg <= sel_ref_next;
            sec_reg <= sec_next;
        end
    end

    // ********
    // crystal and policy settings
    // ********
    logic [8:0] load_reg;
    logic [8:0] load_next;
    logic [1:0] drive_reg;
    logic [1:0] drive_next;
    logic [1:0] policy_reg;
    logic [1:0] policy_next;

    always_comb begin
        load_next = `CGR_LOAD_BASE_EIGHTHS + {1'b0, cfg_reg[IDX_LOAD]};
        drive_next = cfg_reg[IDX_DRIVE][`CGR_DRIVE_MSB:0];
        policy_next = cfg_reg[IDX_REFSEL][`CGR_POLICY_MSB:`CGR_POLICY_LSB];
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            load_reg <= `CGR_LOAD_BASE_EIGHTHS;
            drive_reg <= 2'(`CGR_RST_XTAL_DRIVE);
            policy_reg <= 2'h0;
        end else begin
            load_reg <= load_next;
            drive_reg <= drive_next;
            policy_reg <= policy_next;
        end
    end

    // ********
    // feedback ratio and PLL state
    // ********
    cgr_pkg::cgr_pll_status_t [NUM_PLLS-1:0] status_reg;
    cgr_pkg::cgr_pll_status_t [NUM_PLLS-1:0] status_next;
    logic [NUM_PLLS-1:0] pll_powered;

    always_comb begin
        logic [11:0] n;
        logic [3:0] a;
        logic [13:0] integer_part;
        logic [5:0] frac;
        logic spread_on;
        n = 12'h000;
        a = 4'h0;
        integer_part = 14'h0000;
        frac = 6'h00;
        spread_on = 1'b0;
        for (int p = 0; p < NUM_PLLS; p++) begin
            n = {cfg_reg[IDX_FB + 2 * p + 1][`CGR_NHIGH_MSB:0], cfg_reg[IDX_FB + 2 * p]};
            a = cfg_reg[IDX_FB + 2 * p + 1][`CGR_ADJUST_MSB:`CGR_ADJUST_LSB];
            if (p == 0) begin
                spread_on = cfg_reg[IDX_SS0_CTRL][`CGR_SPREAD_CTRL_MSB:0] != 4'h0;
                frac = cfg_reg[IDX_SS0_OFS][`CGR_SPREAD_OFS_MSB:0];
            end else begin
                spread_on = cfg_reg[IDX_SS1_CTRL][`CGR_SPREAD_CTRL_MSB:0] != 4'h0;
                frac = cfg_reg[IDX_SS1_OFS][`CGR_SPREAD_OFS_MSB:0];
            end
            // adjust code zero cancels the +1 term
            integer_part = {1'b0, n, 1'b0} + ((a == 4'h0) ? 14'h0000 : 14'({a} + 5'h01));
            if (p < 2) begin
                status_next[p].ratio_q6 = {integer_part, spread_on ? frac : 6'h00};
            end else begin
                status_next[p].ratio_q6 = {2'h0, n, 6'h00};
            end
            status_next[p].vco_min = (n == 12'h000);
            status_next[p].powered = (cfg_reg[IDX_PRE + p] != 8'h00);
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    // ********
    // pre-scalers
    // ********
    generate
        for (genvar p = 0; p < NUM_PLLS; p++) begin : g_pre
            cgr_prescale #(
                .D_WIDTH(8)
            ) u_prescale (
                .clock_i(clock_i),
                .sys_rst_i(sys_rst_i),
                .ref_level_i(sel_ref_reg),
                .divide_i(cfg_reg[IDX_PRE + p]),
                .pfd_tick_o(pfd_tick_o[p]),
                .powered_o(pll_powered[p])
            );
        end
    endgenerate

    // ********
    // output banks
    // ********
    cgr_pkg::cgr_bank_cfg_t [NUM_DIV_BANKS-1:0] bank_cfg;
    logic [NUM_DIV_BANKS:0] bank_src_powered;
    logic [NUM_DIV_BANKS:0] bank_src_tick;
    logic [1:0] bank1_src;
    logic bank1_clk_reg;
    logic bank1_clk_next;
    logic [NUM_DIV_BANKS:0] bank_pwr_reg;
    logic [NUM_DIV_BANKS:0] bank_pwr_next;

    always_comb begin
        logic [1:0] src;
        src = 2'h0;
        bank1_src = cfg_reg[IDX_BANK1][1:0];
        bank_src_powered[0] = (bank1_src < 2'(NUM_PLLS)) && pll_powered[bank1_src];
        bank_src_tick[0] = (bank1_src < 2'(NUM_PLLS)) && vco_tick_i[bank1_src];
        for (int b = 0; b < NUM_DIV_BANKS; b++) begin
            bank_cfg[b].q = {cfg_reg[IDX_POST + 2 * b + 1][`CGR_QHIGH_MSB:0], cfg_reg[IDX_POST + 2 * b]};
            bank_cfg[b].mode = cfg_reg[IDX_POST + 2 * b + 1][`CGR_PM_MSB:`CGR_PM_LSB];
            bank_cfg[b].source = cfg_reg[IDX_POST + 2 * b + 1][`CGR_SRC_MSB:`CGR_SRC_LSB];
            src = bank_cfg[b].source;
            bank_src_powered[b + 1] = (src < 2'(NUM_PLLS)) && pll_powered[src];
            bank_src_tick[b + 1] = (src < 2'(NUM_PLLS)) && vco_tick_i[src];
        end
        // first bank follows its PLL directly
        bank1_clk_next = bank_src_powered[0] && bank_src_tick[0];
        bank_pwr_next = bank_src_powered;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            bank1_clk_reg <= 1'b0;
            bank_pwr_reg <= '0;
        end else begin
            bank1_clk_reg <= bank1_clk_next;
            bank_pwr_reg <= bank_pwr_next;
        end
    end

    generate
        for (genvar b = 0; b < NUM_DIV_BANKS; b++) begin : g_post
            cgr_postdiv #(
                .Q_WIDTH(10)
            ) u_postdiv (
                .clock_i(clock_i),
                .sys_rst_i(sys_rst_i),
                .vco_tick_i(bank_src_tick[b + 1]),
                .powered_i(bank_src_powered[b + 1]),
                .mode_i(bank_cfg[b].mode),
                .q_i(bank_cfg[b].q),
                .bank_clk_o(bank_clk_o[b + 1]),
                .running_o()
            );
        end
    endgenerate

    // ********
    // outputs
    // ********
    assign cfg_rdata_o = rdata_reg;
    assign cfg_rvalid_o = rvalid_reg;
    assign selected_ref_o = sel_ref_reg;
    assign ref_is_secondary_o = sec_reg;
    assign pll_status_o = status_reg;
    assign crystal_load_eighths_o = load_reg;
    assign crystal_drive_strength_o = drive_reg;
    assign switchover_policy_o = policy_reg;
    assign bank_clk_o[0] = bank1_clk_reg;
    assign bank_powered_o = bank_pwr_reg;

endmodule : cgr_ref_pll_cfg

// ---- bench/cgr_ref_pll_cfg_properties.sv ----
// concurrent checks on the ports of the reference and divider block
`timescale 1ns/10ps
module cgr_ref_pll_cfg_chk #(
    parameter int NUM_PLLS = 3,
    parameter int NUM_DIV_BANKS = 5
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic multipurpose_input_five_i,
    input wire logic [1:0] manual_frequency_control_i,
    input wire logic [NUM_PLLS-1:0] vco_tick_i,
    input wire logic ref_is_secondary_o,
    input wire logic [NUM_PLLS-1:0] pfd_tick_o,
    input wire cgr_pkg::cgr_pll_status_t [NUM_PLLS-1:0] pll_status_o,
    input wire logic [8:0] crystal_load_eighths_o,
    input wire logic [1:0] crystal_drive_strength_o,
    input wire logic [1:0] switchover_policy_o,
    input wire logic [NUM_DIV_BANKS:0] bank_clk_o,
    input wire logic [NUM_DIV_BANKS:0] bank_powered_o
);
    // ********
    // register port, field decode, selection and power gating
    // ********
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_wr(logic [7:0] a);
        cfg_wr_i && cfg_addr_i == a;
    endsequence
    property p_load;
        logic [7:0] d;
        (s_wr(8'h07), d = cfg_wdata_i) |-> ##2 crystal_load_eighths_o == 9'h01c + d;
    endproperty
    property p_drive;
        logic [7:0] d;
        (s_wr(8'h06), d = cfg_wdata_i) |-> ##2 crystal_drive_strength_o == d[1:0];
    endproperty
    property p_policy;
        logic [7:0] d;
        (s_wr(8'h34), d = cfg_wdata_i) |-> ##2 switchover_policy_o == d[2:1];
    endproperty
    chk_load_code: assert property (p_load) else $error("load output wrong after write");
    chk_drive_field: assert property (p_drive) else $error("drive output wrong after write");
    chk_policy_field: assert property (p_policy) else $error("policy output wrong after write");
    chk_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o) else $error("read not answered");
    chk_read_quiet: assert property (!cfg_rd_i |=> !cfg_rvalid_o) else $error("answer without read");
    chk_rdata_idle: assert property (!cfg_rvalid_o |-> cfg_rdata_o == 8'h00) else $error("read data not idle");
    chk_ref_choice: assert property (!$past(sys_rst_i) |-> ref_is_secondary_o ==
        $past(multipurpose_input_five_i && manual_frequency_control_i != 2'h2)) else $error("wrong reference");
    chk_bank0_direct: assert property (bank_clk_o[0] |-> $past(vco_tick_i) != '0) else $error("first bank");
    chk_pll_down: assert property (!pll_status_o[0].powered [*3] |-> !pfd_tick_o[0]) else $error("pfd live");
    chk_bank_down: assert property (!bank_powered_o[1] [*3] |-> !bank_clk_o[1]) else $error("bank live");
endmodule : cgr_ref_pll_cfg_chk

bind cgr_ref_pll_cfg cgr_ref_pll_cfg_chk #(.NUM_PLLS(NUM_PLLS), .NUM_DIV_BANKS(NUM_DIV_BANKS)) u_cgr_ref_pll_cfg_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .multipurpose_input_five_i(multipurpose_input_five_i), .manual_frequency_control_i(manual_frequency_control_i),
    .vco_tick_i(vco_tick_i), .ref_is_secondary_o(ref_is_secondary_o), .pfd_tick_o(pfd_tick_o),
    .pll_status_o(pll_status_o), .crystal_load_eighths_o(crystal_load_eighths_o),
    .crystal_drive_strength_o(crystal_drive_strength_o), .switchover_policy_o(switchover_policy_o),
    .bank_clk_o(bank_clk_o), .bank_powered_o(bank_powered_o)
);

// ---- bench/cgr_ref_src.sv ----
// free-running models of the crystal and second reference sources
`timescale 1ns/10ps
module cgr_ref_src (
    input wire logic clock_i,
    output logic crystal_o = 1'b0,
    output logic second_o = 1'b1
);
    // ********
    // crystal toggles every 3 cycles, second input every 4
    // ********
    int cnt = 0;
    always @(posedge clock_i) begin
        cnt <= (cnt == 11) ? 0 : cnt + 1;
        if (cnt % 3 == 2) crystal_o <= ~crystal_o;
        if (cnt % 4 == 3) second_o <= ~second_o;
    end
endmodule : cgr_ref_src

// ---- bench/cgr_ref_pll_cfg_test.sv ----
// self-checking bench of the reference selection and divider block
`timescale 1ns/10ps
module cgr_ref_pll_cfg_test;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, sel_pin = 1'b0, tick_all = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o;
    logic cfg_rvalid_o, xtal, sec, sel_ref, is_sec, seen;
    logic [1:0] manual_frequency_control = 2'h0, drive, policy, c;
    logic [2:0] vco = 3'h0, pfd;
    cgr_pkg::cgr_pll_status_t [2:0] status;
    logic [8:0] load;
    logic [5:0] bclk, bpwr;
    logic [31:0] r;
    logic [11:0] n;
    int error_cnt = 0, n_tests = 0, seed = 81, i, m, g, q, dd;
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) vco <= tick_all ? 3'h7 : 3'($random(seed));
    cgr_ref_src u_cgr_ref_src (.clock_i(clock_i), .crystal_o(xtal), .second_o(sec));
    cgr_ref_pll_cfg u_cgr_ref_pll_cfg (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cfg_wr_i(cfg_wr_i),
        .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_rvalid_o(cfg_rvalid_o), .crystal_reference_input_i(xtal), .second_reference_input_i(sec),
        .multipurpose_input_five_i(sel_pin), .manual_frequency_control_i(manual_frequency_control), .vco_tick_i(vco),
        .selected_ref_o(sel_ref), .ref_is_secondary_o(is_sec), .pfd_tick_o(pfd), .pll_status_o(status),
        .crystal_load_eighths_o(load), .crystal_drive_strength_o(drive), .switchover_policy_o(policy),
        .bank_clk_o(bclk), .bank_powered_o(bpwr));
    // ********
    // shared tasks
    // ********
    task cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_wdata_i <= d;
        @(posedge clock_i);
        cfg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge clock_i);
        cfg_rd_i <= 1'b0;
        #1 cmp("rdata", {11'h000, 1'b1, d}, {11'h000, cfg_rvalid_o, cfg_rdata_o});
    endtask : rd
    task settle;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : settle
    // cycles between two rising edges of a bank clock or of the first pfd tick
    task gap_of(input int w, output int gap);
        logic p, s;
        int k, hits;
        hits = 0;
        gap = 0;
        p = 1'b1;
        for (k = 0; k < 400 && hits < 2; k++) begin
            @(posedge clock_i);
            #1 s = (w < 6) ? bclk[w] : pfd[0];
            if (hits == 1) gap++;
            if (s && !p) hits++;
            p = s;
        end
        if (hits < 2) begin
            $display("BAD wait for edges expected 2 seen %0d", hits);
            error_cnt++;
            end_sim();
        end
    endtask : gap_of
    function automatic logic [19:0] exp_ratio(input int p, input logic [11:0] nn, input logic [3:0] a,
                                              input logic sp, input logic [5:0] ofs);
        int k;
        k = (p == 2) ? nn * 64 : (2 * nn + (a == 4'h0 ? 0 : a + 1)) * 64 + (sp ? ofs : 0);
        return k[19:0];
    endfunction : exp_ratio
    // ********
    // main sequence
    // ********
    initial begin
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(8'h06, 8'h03);
        rd(8'h07, 8'h00);
        rd(8'hff, 8'h00);
        cmp("load", 20'h0001c, {11'h000, load});
        cmp("drive", 20'h00003, {18'h00000, drive});
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(8'h07, r[7:0]);
            settle();
            cmp("load", 20'h0001c + r[7:0], {11'h000, load});
            rd(8'h06, 8'h03);
        end
        wr(8'h07, 8'h00);
        $display("test registers done");
        for (i = 0; i < 16; i++) begin
            wr(8'h34, {7'h00, i[0]});
            sel_pin <= i[1];
            manual_frequency_control <= i[3:2];
            settle();
            c = {xtal, sec};
            m = (i[1] && i[3:2] != 2'h2) ? 1 : 0;
            @(posedge clock_i);
            #1 cmp("select", {m[0], (m[0] ^ i[0]) ? c[0] : c[1]}, {is_sec, sel_ref});
        end
        $display("test selection done");
        wr(8'h34, 8'h00);
        sel_pin <= 1'b0;
        for (i = 0; i < 3; i++) begin
            r = $random(seed);
            n = {2'h0, r[9:0]} + 12'h015;
            wr(8'h40 + i[7:0], r[28:21] | 8'h01);
            wr(8'h48 + {i[6:0], 1'b0}, n[7:0]);
            wr(8'h49 + {i[6:0], 1'b0}, {r[13:10], n[11:8]});
            if (i < 2) begin
                wr(8'h60 + {i[4:0], 3'h0}, {7'h00, r[20]});
                wr(8'h61 + {i[4:0], 3'h0}, {2'h0, r[19:14]});
            end
            settle();
            cmp("ratio", exp_ratio(i, n, r[13:10], r[20], r[19:14]), status[i].ratio_q6);
            cmp("state", 20'h00002, {18'h00000, status[i].powered, status[i].vco_min});
        end
        dd = 1 + ($random(seed) & 3);
        wr(8'h40, 8'(dd));
        settle();
        gap_of(6, g);
        cmp("pfd", 20'(6 * dd), 20'(g));
        tick_all <= 1'b1;
        for (m = 0; m < 4; m++) begin
            q = $random(seed) & 15;
            wr(8'h50 + {m[6:0], 1'b0}, 8'(q));
            wr(8'h51 + {m[6:0], 1'b0}, {4'h0, m[1:0], 2'h0});
            settle();
            if (m == 0) begin
                seen = 1'b0;
                repeat (30) begin
                    @(posedge clock_i);
                    #1 seen = seen | bclk[1];
                end
                cmp("off", 20'h00001, {18'h00000, seen, bpwr[1]});
            end else begin
                gap_of(m + 1, g);
                cmp("period", 20'(m == 3 ? 2 * q + 4 : 2 * m), 20'(g));
            end
        end
        $display("test post dividers done");
        wr(8'h4a, 8'h00);
        wr(8'h4b, 8'h00);
        wr(8'h40, 8'h00);
        settle();
        cmp("down", 20'h00001, {17'h00000, status[0].powered, bpwr[2], status[1].vco_min});
        $display("test power down done");
        end_sim();
    end
endmodule : cgr_ref_pll_cfg_test
